// ===== rtl/dhs_pkg.sv
// shared constants for the acquisition host-side pin block
// Contract
// RULE1 - sync pin as input: rising edge makes sample-and-hold capture input
// RULE2 - after sync edge, next clock starts conversion or comparison per instruction
// RULE3 - direction bit low makes sync an input, high drives it as output
// RULE4 - output mode: sync high at operation start, low at completion
// RULE5 - reset leaves the sync pin configured as an input
// RULE6 - width select high: 8-bit bus, upper lines floated; low: 16-bit
// RULE7 - active-low interrupt asserts on any unmasked interrupt condition
// RULE8 - eight interrupt sources, each individually maskable
// RULE9 - reading interrupt status clears all pending and releases interrupt
// RULE10 - dma request rises when fifo count equals programmed threshold
// RULE11 - dma request drops once the fifo has been emptied
// RULE12 - five address lines select registers, fifo and instruction ram
// RULE13 - channels from instruction ram; any single-ended or any pair differential
// RULE14 - chip select low halts internal clocking and suspends conversion
// RULE15 - multiplexed bus: address latched on latch-strobe fall with select low
// RULE16 - data lines driven only while read strobe and select both low
// RULE17 - data accepted only while write strobe and select both low
// RULE18 - interrupt stays low until status read, not when source goes away
package dhs_pkg;

    // ****************************************
    // bus geometry
    // ****************************************
    localparam int ADDR_W = 5;
    localparam int DATA_W = 16;
    localparam int BYTE_W = 8;
    localparam int IRQ_SRC_N = 8;
    localparam int FIFO_CNT_W = 6;
    localparam int CHAN_W = 3;

    // ****************************************
    // address map and reset values
    // ****************************************
    localparam logic [ADDR_W-1:0] INT_STATUS_ADDR = 5'h0c;
    localparam logic SYNC_DIR_RST = 1'b0;
    localparam logic [IRQ_SRC_N-1:0] IRQ_PEND_RST = 8'h00;
    localparam logic [FIFO_CNT_W-1:0] FIFO_EMPTY = 6'h00;

    // ****************************************
    // conversion sequencing states
    // ****************************************
    typedef enum logic [1:0] {
        DHS_IDLE = 2'b00,
        DHS_HELD = 2'b01,
        DHS_BUSY = 2'b10
    } dhs_state_t;

endpackage : dhs_pkg

// ===== rtl/dhs_edge_det.sv
// one-cycle edge pulse from a synchronous level
`timescale 1ns/1ns
module dhs_edge_det #(
    parameter bit RISING = 1'b1
) (
    // clock and reset
    input wire logic clk_sys_in,
    input wire logic reset_in,
    // level and pulse
    input wire logic level_in,
    output logic pulse_out
);

    logic prev_r;
    logic prev_nxt;

    always_comb begin
        prev_nxt = level_in;
    end

    always_ff @(posedge clk_sys_in) begin
        if (reset_in) begin
            prev_r <= RISING ? 1'b1 : 1'b0;
        end else begin
            prev_r <= prev_nxt;
        end
    end

    // reset value suppresses a false edge right after release
    assign pulse_out = RISING ? (level_in & ~prev_r) : (~level_in & prev_r);

endmodule : dhs_edge_det

// ===== rtl/dhs_host_port.sv
// host-side pins: sync, bus width, interrupt, dma request, bus strobes
`timescale 1ns/1ns
module dhs_host_port (
    // clock and reset
    input wire logic clk_sys_in,
    input wire logic reset_in,
    // host bus control
    input wire logic cs_n_in,
    input wire logic rd_n_in,
    input wire logic wr_n_in,
    input wire logic ale_in,
    input wire logic bus_width_select_in,
    input wire logic [dhs_pkg::ADDR_W-1:0] register_address_lines_in,
    // host data lines, split three ways
    input wire logic [dhs_pkg::DATA_W-1:0] host_data_lines_in,
    output logic [dhs_pkg::DATA_W-1:0] host_data_lines_out,
    output logic [dhs_pkg::DATA_W-1:0] host_data_lines_oe_out,
    // internal register side
    output logic [dhs_pkg::ADDR_W-1:0] reg_addr_out,
    output logic bus_8bit_out,
    output logic reg_rd_out,
    output logic reg_wr_out,
    output logic [dhs_pkg::DATA_W-1:0] reg_wdata_out,
    input wire logic [dhs_pkg::DATA_W-1:0] reg_rdata_in,
    // sync pin
    input wire logic sync_in,
    output logic sync_out,
    output logic sync_oe_out,
    // configuration and sequencer
    input wire logic io_select_in,
    input wire logic op_start_req_in,
    input wire logic op_compare_in,
    input wire logic op_done_in,
    input wire logic [dhs_pkg::CHAN_W-1:0] ram_chan_pos_in,
    input wire logic [dhs_pkg::CHAN_W-1:0] ram_chan_neg_in,
    input wire logic ram_chan_diff_in,
    output logic sample_hold_out,
    output logic start_convert_out,
    output logic start_compare_out,
    output logic conv_run_out,
    output logic [dhs_pkg::CHAN_W-1:0] mux_pos_out,
    output logic [dhs_pkg::CHAN_W-1:0] mux_neg_out,
    output logic mux_diff_out,
    // interrupt sources
    input wire logic [dhs_pkg::IRQ_SRC_N-1:0] irq_event_in,
    input wire logic [dhs_pkg::IRQ_SRC_N-1:0] irq_enable_in,
    output logic [dhs_pkg::IRQ_SRC_N-1:0] irq_pending_out,
    output logic int_n_out,
    // fifo level and dma
    input wire logic [dhs_pkg::FIFO_CNT_W-1:0] fifo_count_in,
    input wire logic [dhs_pkg::FIFO_CNT_W-1:0] dma_threshold_in,
    output logic dma_request_out
);

    // ****************************************
    // edge detection
    // ****************************************
    logic sync_rise;
    logic ale_fall;
    logic rd_fall;
    logic wr_rise;

    dhs_edge_det #(.RISING(1'b1)) u_sync_edge (
        .clk_sys_in(clk_sys_in),
        .reset_in(reset_in),
        .level_in(sync_in),
        .pulse_out(sync_rise)
    );

    dhs_edge_det #(.RISING(1'b0)) u_ale_edge (
        .clk_sys_in(clk_sys_in),
        .reset_in(reset_in),
        .level_in(ale_in),
        .pulse_out(ale_fall)
    );

    dhs_edge_det #(.RISING(1'b0)) u_rd_edge (
        .clk_sys_in(clk_sys_in),
        .reset_in(reset_in),
        .level_in(rd_n_in | cs_n_in),
        .pulse_out(rd_fall)
    );

    dhs_edge_det #(.RISING(1'b1)) u_wr_edge (
        .clk_sys_in(clk_sys_in),
        .reset_in(reset_in),
        .level_in(wr_n_in | cs_n_in),
        .pulse_out(wr_rise)
    );

    // ****************************************
    // address latch and bus strobes
    // ****************************************
    logic [dhs_pkg::ADDR_W-1:0] addr_r;
    logic [dhs_pkg::ADDR_W-1:0] addr_nxt;
    logic [dhs_pkg::ADDR_W-1:0] addr_eff;
    logic [dhs_pkg::ADDR_W-1:0] addr_seen_r;
    logic [dhs_pkg::ADDR_W-1:0] addr_seen_nxt;
    logic [dhs_pkg::DATA_W-1:0] wdata_r;
    logic [dhs_pkg::DATA_W-1:0] wdata_nxt;
    logic [dhs_pkg::DATA_W-1:0] rdata_r;
    logic [dhs_pkg::DATA_W-1:0] rdata_nxt;
    logic rd_active;
    logic wr_active;

    assign rd_active = ~rd_n_in & ~cs_n_in;
    assign wr_active = ~wr_n_in & ~cs_n_in;
    // latch strobe held high means a non-multiplexed bus: address flows
    assign addr_eff = ale_in ? register_address_lines_in :
        ((ale_fall && !cs_n_in) ? addr_seen_r : addr_r); // RULE15

    always_comb begin
        // lines may already carry data once the strobe is low, so the
        // latch takes the last address seen while the strobe was high
        addr_seen_nxt = ale_in ? register_address_lines_in : addr_seen_r;
        addr_nxt = addr_r;
        if (ale_fall && !cs_n_in) begin
            addr_nxt = addr_seen_r; // RULE15
        end
        wdata_nxt = wdata_r;
        if (wr_active) begin
            wdata_nxt = host_data_lines_in; // RULE17
            if (bus_width_select_in) begin
                wdata_nxt[dhs_pkg::DATA_W-1:dhs_pkg::BYTE_W] = 8'h00; // RULE6
            end
        end
        rdata_nxt = rdata_r;
        if (rd_active) begin
            rdata_nxt = reg_rdata_in;
        end
    end

    always_ff @(posedge clk_sys_in) begin
        if (reset_in) begin
            addr_r <= 5'h00;
            addr_seen_r <= 5'h00;
            wdata_r <= 16'h0000;
            rdata_r <= 16'h0000;
        end else begin
            addr_r <= addr_nxt;
            addr_seen_r <= addr_seen_nxt;
            wdata_r <= wdata_nxt;
            rdata_r <= rdata_nxt;
        end
    end

    assign reg_addr_out = addr_eff; // RULE12
    assign bus_8bit_out = bus_width_select_in; // RULE6
    assign reg_rd_out = rd_fall;
    // write completes when either strobe rises, data as last seen active
    assign reg_wr_out = wr_rise; // RULE17
    assign reg_wdata_out = wdata_r;
    assign host_data_lines_out = rdata_r;

    always_comb begin
        host_data_lines_oe_out = {dhs_pkg::DATA_W{rd_active}}; // RULE16
        if (bus_width_select_in) begin
            host_data_lines_oe_out[dhs_pkg::DATA_W-1:dhs_pkg::BYTE_W] =
                8'h00; // RULE6
        end
    end

    // ****************************************
    // sync direction and conversion sequencing
    // ****************************************
    dhs_pkg::dhs_state_t state_r;
    dhs_pkg::dhs_state_t state_nxt;
    logic sync_dir_r;
    logic sync_dir_nxt;
    logic op_cmp_r;
    logic op_cmp_nxt;
    logic start_cv_r;
    logic start_cv_nxt;
    logic start_cp_r;
    logic start_cp_nxt;
    logic [dhs_pkg::CHAN_W-1:0] pos_r;
    logic [dhs_pkg::CHAN_W-1:0] pos_nxt;
    logic [dhs_pkg::CHAN_W-1:0] neg_r;
    logic [dhs_pkg::CHAN_W-1:0] neg_nxt;
    logic diff_r;
    logic diff_nxt;
    logic run_en;

    // host access blocks starts into DHS_BUSY; a pending start waits it out
    assign run_en = cs_n_in; // RULE14

    always_comb begin
        sync_dir_nxt = io_select_in; // RULE3
        state_nxt = state_r;
        op_cmp_nxt = op_cmp_r;
        start_cv_nxt = 1'b0;
        start_cp_nxt = 1'b0;
        pos_nxt = pos_r;
        neg_nxt = neg_r;
        diff_nxt = diff_r;
        case (state_r)
            dhs_pkg::DHS_IDLE: begin
                if (!sync_dir_r && sync_rise) begin
                    state_nxt = dhs_pkg::DHS_HELD; // RULE1
                    op_cmp_nxt = op_compare_in;
                end else if (sync_dir_r && op_start_req_in && run_en) begin
                    state_nxt = dhs_pkg::DHS_BUSY; // RULE4
                    start_cv_nxt = ~op_compare_in;
                    start_cp_nxt = op_compare_in;
                    pos_nxt = ram_chan_pos_in; // RULE13
                    neg_nxt = ram_chan_neg_in;
                    diff_nxt = ram_chan_diff_in;
                end
            end
            dhs_pkg::DHS_HELD: begin
                if (run_en) begin
                    state_nxt = dhs_pkg::DHS_BUSY; // RULE2
                    start_cv_nxt = ~op_cmp_r;
                    start_cp_nxt = op_cmp_r;
                    pos_nxt = ram_chan_pos_in; // RULE13
                    neg_nxt = ram_chan_neg_in;
                    diff_nxt = ram_chan_diff_in;
                end
            end
            dhs_pkg::DHS_BUSY: begin
                if (op_done_in) begin
                    state_nxt = dhs_pkg::DHS_IDLE; // RULE4
                end
            end
            default: begin
                state_nxt = dhs_pkg::DHS_IDLE;
            end
        endcase
    end

    always_ff @(posedge clk_sys_in) begin
        if (reset_in) begin
            state_r <= dhs_pkg::DHS_IDLE;
            sync_dir_r <= dhs_pkg::SYNC_DIR_RST; // RULE5
            op_cmp_r <= 1'b0;
            start_cv_r <= 1'b0;
            start_cp_r <= 1'b0;
            pos_r <= 3'h0;
            neg_r <= 3'h0;
            diff_r <= 1'b0;
        end else begin
            state_r <= state_nxt;
            sync_dir_r <= sync_dir_nxt;
            op_cmp_r <= op_cmp_nxt;
            start_cv_r <= start_cv_nxt;
            start_cp_r <= start_cp_nxt;
            pos_r <= pos_nxt;
            neg_r <= neg_nxt;
            diff_r <= diff_nxt;
        end
    end

    assign sync_oe_out = sync_dir_r; // RULE3
    assign sync_out = sync_dir_r & (state_r == dhs_pkg::DHS_BUSY); // RULE4
    assign sample_hold_out = (state_r != dhs_pkg::DHS_IDLE); // RULE1
    assign start_convert_out = start_cv_r; // RULE2
    assign start_compare_out = start_cp_r;
    assign conv_run_out = run_en; // RULE14
    assign mux_pos_out = pos_r;
    assign mux_neg_out = neg_r;
    assign mux_diff_out = diff_r;

    // ****************************************
    // interrupt pending and dma request
    // ****************************************
    logic [dhs_pkg::IRQ_SRC_N-1:0] pend_r;
    logic [dhs_pkg::IRQ_SRC_N-1:0] pend_nxt;
    logic dma_r;
    logic dma_nxt;
    logic status_rd;

    assign status_rd = rd_fall && (addr_eff == dhs_pkg::INT_STATUS_ADDR);

    always_comb begin
        pend_nxt = pend_r;
        if (status_rd) begin
            pend_nxt = dhs_pkg::IRQ_PEND_RST; // RULE9
        end
        // new events beat a same-cycle clear so none is lost
        pend_nxt = pend_nxt | (irq_event_in & irq_enable_in); // RULE8 RULE18
        dma_nxt = dma_r;
        if (fifo_count_in == dhs_pkg::FIFO_EMPTY) begin
            dma_nxt = 1'b0; // RULE11
        end else if (fifo_count_in == dma_threshold_in) begin
            dma_nxt = 1'b1; // RULE10
        end
    end

    always_ff @(posedge clk_sys_in) begin
        if (reset_in) begin
            pend_r <= dhs_pkg::IRQ_PEND_RST;
            dma_r <= 1'b0;
        end else begin
            pend_r <= pend_nxt;
            dma_r <= dma_nxt;
        end
    end

    assign irq_pending_out = pend_r;
    assign int_n_out = ~(|pend_r); // RULE7
    assign dma_request_out = dma_r;

endmodule : dhs_host_port

// ===== test/dhs_host_port_properties.sv
// assertions on the host-side pin block ports
`timescale 1ns/1ns
module dhs_host_port_props (
    // clock and reset
    input wire logic clk_sys_in,
    input wire logic reset_in,
    // host bus
    input wire logic cs_n_in,
    input wire logic rd_n_in,
    input wire logic bus_width_select_in,
    input wire logic [15:0] host_data_lines_oe_out,
    input wire logic [4:0] reg_addr_out,
    input wire logic reg_rd_out,
    // sync and sequencer
    input wire logic sync_in,
    input wire logic sync_out,
    input wire logic sync_oe_out,
    input wire logic sample_hold_out,
    input wire logic start_convert_out,
    input wire logic start_compare_out,
    input wire logic conv_run_out,
    // interrupt and dma
    input wire logic [7:0] irq_event_in,
    input wire logic [7:0] irq_enable_in,
    input wire logic int_n_out,
    input wire logic [5:0] fifo_count_in,
    input wire logic [5:0] dma_threshold_in,
    input wire logic dma_request_out
);
    // ****************************************
    // properties
    // ****************************************
    default clocking @(posedge clk_sys_in); endclocking
    default disable iff (reset_in);
    wire stat_rd = reg_rd_out && reg_addr_out == dhs_pkg::INT_STATUS_ADDR;
    wire irq_hit = |(irq_event_in & irq_enable_in);
    a_oe_needs_rd: assert property (
        |host_data_lines_oe_out |-> !rd_n_in && !cs_n_in)
        else $error("data lines driven without read");
    a_narrow_float: assert property (
        bus_width_select_in |-> host_data_lines_oe_out[15:8] == 8'h00)
        else $error("upper lines driven on narrow bus");
    a_halt_conv: assert property (!cs_n_in |-> !conv_run_out)
        else $error("conversion runs while selected");
    a_halt_start: assert property (
        !cs_n_in |=> !start_convert_out && !start_compare_out)
        else $error("operation started while selected");
    a_irq_raise: assert property (irq_hit |=> !int_n_out)
        else $error("interrupt not raised");
    a_irq_sticky: assert property (
        !int_n_out && !stat_rd |=> !int_n_out)
        else $error("interrupt released without status read");
    a_stat_clear: assert property (stat_rd && !irq_hit |=> int_n_out)
        else $error("status read left interrupt set");
    a_dma_rise: assert property (
        fifo_count_in != 6'h00 && fifo_count_in == dma_threshold_in
        |=> dma_request_out)
        else $error("dma request not raised");
    a_dma_drop: assert property (fifo_count_in == 6'h00 |=> !dma_request_out)
        else $error("dma request not dropped");
    a_hold_capture: assert property (
        $rose(sync_in) && !$past(reset_in) && !sync_oe_out
        && !sample_hold_out |=> sample_hold_out)
        else $error("sync edge did not hold input");
    a_start_next: assert property (
        $rose(sample_hold_out) && !sync_oe_out && cs_n_in
        |=> start_convert_out != start_compare_out)
        else $error("no start after hold");
    a_sync_rise: assert property (
        sync_oe_out && (start_convert_out || start_compare_out) |-> sync_out)
        else $error("sync output low at start");
    a_reset_dir: assert property ($fell(reset_in) |-> !sync_oe_out)
        else $error("sync not input after reset");
    c_hold: cover property ($rose(sample_hold_out));
    c_stat: cover property (stat_rd && !int_n_out);
    c_dma: cover property ($rose(dma_request_out));
    c_halt: cover property (!cs_n_in && sample_hold_out);
endmodule : dhs_host_port_props

bind dhs_host_port dhs_host_port_props u_props (.*);

// ===== test/dhs_host_model.sv
// host processor model driving the parallel bus
`timescale 1ns/1ns
module dhs_host_model (
    // clock and answer
    input wire logic clk_sys_in,
    input wire logic [15:0] dev_data_in,
    // bus strobes, address and data
    output logic cs_n_out,
    output logic rd_n_out,
    output logic wr_n_out,
    output logic ale_out,
    output logic [4:0] addr_out,
    output logic [15:0] data_out
);
    // ****************************************
    // bus cycles
    // ****************************************
    // non-multiplexed bus: latch strobe held high
    initial begin
        cs_n_out = 1'b1;
        rd_n_out = 1'b1;
        wr_n_out = 1'b1;
        ale_out = 1'b1;
        addr_out = 5'h00;
        data_out = 16'h0000;
    end
    // n sets how slowly the host ends the cycle
    task automatic rd(input logic [4:0] a, input int n,
                      output logic [15:0] d);
        @(posedge clk_sys_in);
        cs_n_out <= 1'b0;
        rd_n_out <= 1'b0;
        addr_out <= a;
        repeat (n) @(posedge clk_sys_in);
        d = dev_data_in;
        cs_n_out <= 1'b1;
        rd_n_out <= 1'b1;
        addr_out <= ~a;
    endtask : rd
    // multiplexed cycle: address valid only while the latch strobe is high
    task automatic rd_mux(input logic [4:0] a, input int n,
                          output logic [15:0] d);
        @(posedge clk_sys_in);
        cs_n_out <= 1'b0;
        addr_out <= a;
        @(posedge clk_sys_in);
        ale_out <= 1'b0;
        rd_n_out <= 1'b0;
        addr_out <= ~a;
        repeat (n) @(posedge clk_sys_in);
        d = dev_data_in;
        cs_n_out <= 1'b1;
        rd_n_out <= 1'b1;
        ale_out <= 1'b1;
    endtask : rd_mux
    task automatic wr(input logic [4:0] a, input logic [15:0] v, input int n);
        @(posedge clk_sys_in);
        cs_n_out <= 1'b0;
        wr_n_out <= 1'b0;
        addr_out <= a;
        data_out <= v;
        repeat (n) @(posedge clk_sys_in);
        cs_n_out <= 1'b1;
        wr_n_out <= 1'b1;
        addr_out <= ~a;
        // released lines must not look held
        data_out <= ~v;
    endtask : wr
endmodule : dhs_host_model

// ===== test/test_dhs_host_port.sv
// self-checking bench for the host-side pin block
`timescale 1ns/1ns
module test_dhs_host_port;
    logic clk_sys_in = 1'b0;
    logic reset_in = 1'b1;
    logic cs_n_in, rd_n_in, wr_n_in, ale_in, bus_8bit_out;
    logic bus_width_select_in = 1'b0;
    logic [4:0] register_address_lines_in, reg_addr_out, acap;
    logic [15:0] host_data_lines_in, host_data_lines_out;
    logic [15:0] host_data_lines_oe_out, reg_wdata_out, d, oe_seen, wcap;
    logic [15:0] reg_rdata_in = 16'h5a3c;
    logic reg_rd_out, reg_wr_out, sync_out, sync_oe_out;
    logic run_seen;
    logic sync_in = 1'b0, io_select_in = 1'b0, op_start_req_in = 1'b0;
    logic op_compare_in = 1'b0, op_done_in = 1'b0, ram_chan_diff_in = 1'b1;
    logic [2:0] ram_chan_pos_in = 3'h6, ram_chan_neg_in = 3'h1;
    logic sample_hold_out, start_convert_out, start_compare_out;
    logic conv_run_out, mux_diff_out, int_n_out, dma_request_out;
    logic [2:0] mux_pos_out, mux_neg_out;
    logic [7:0] irq_event_in = 8'h00, irq_enable_in = 8'h00, irq_pending_out;
    logic [5:0] fifo_count_in = 6'h00, dma_threshold_in = 6'h05;
    logic [5:0] cnt [4] = '{6'h03, 6'h05, 6'h02, 6'h00};
    logic [3:0] dx = 4'h6;
    int fail_count = 0;
    int n_checks = 0;
    int n_rd = 0;
    int k;

    dhs_host_port dut (.*);
    // lanes the block does not drive read back inverted, never as held
    dhs_host_model host (
        .clk_sys_in(clk_sys_in),
        .dev_data_in(~(host_data_lines_out ^ host_data_lines_oe_out)),
        .cs_n_out(cs_n_in), .rd_n_out(rd_n_in), .wr_n_out(wr_n_in),
        .ale_out(ale_in), .addr_out(register_address_lines_in),
        .data_out(host_data_lines_in));

    // ****************************************
    // clock, monitors, helpers
    // ****************************************
    initial forever #10 clk_sys_in = ~clk_sys_in;
    always @(negedge clk_sys_in) if (!cs_n_in && !rd_n_in) begin
        oe_seen <= host_data_lines_oe_out;
        acap <= reg_addr_out;
        run_seen <= conv_run_out;
    end
    always @(posedge clk_sys_in) if (reg_wr_out) wcap <= reg_wdata_out;
    always @(posedge clk_sys_in) if (reg_rd_out) n_rd <= n_rd + 1;

    task chk(input string nm, input logic [15:0] got, input logic [15:0] exp);
        n_checks++;
        if (got !== exp) begin
            $display("[FAIL] %s expected %h got %h", nm, exp, got);
            fail_count++;
        end
    endtask : chk
    task cyc(input int n);
        repeat (n) @(negedge clk_sys_in);
    endtask : cyc
    task wrap_up;
        $display("checks %0d mismatches %0d", n_checks, fail_count);
        if (fail_count == 0 && n_checks > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask : wrap_up

    // ****************************************
    // scenarios
    // ****************************************
    task t_bus;
        host.rd(5'h03, 3, d);
        cyc(1);
        chk("read data", d, 16'h5a3c);
        chk("read lanes", oe_seen, 16'hffff);
        chk("lanes idle", host_data_lines_oe_out, 16'h0000);
        chk("address", {11'h000, acap}, 16'h0003);
        chk("read strobes", n_rd[15:0], 16'h0001);
        @(posedge clk_sys_in) bus_width_select_in <= 1'b1;
        host.rd(5'h1e, 2, d);
        chk("narrow lanes", oe_seen, 16'h00ff);
        chk("narrow data", d, 16'ha53c);
        chk("width flag", {15'h0, bus_8bit_out}, 16'h0001);
        host.wr(5'h05, 16'ha5c3, 2);
        cyc(2);
        chk("narrow write", wcap, 16'h00c3);
        @(posedge clk_sys_in) bus_width_select_in <= 1'b0;
        host.wr(5'h05, 16'ha5c3, 3);
        cyc(2);
        chk("wide write", wcap, 16'ha5c3);
        host.rd_mux(5'h0a, 2, d);
        chk("latched address", {11'h000, acap}, 16'h000a);
        chk("muxed data", d, 16'h5a3c);
        $display("bus test done");
    endtask : t_bus
    task t_irq;
        for (k = 0; k < 8; k++) begin
            @(posedge clk_sys_in) irq_enable_in <= 8'h01 << k;
            irq_event_in <= ~(8'h01 << k);
            @(posedge clk_sys_in) irq_event_in <= 8'h01 << k;
            @(negedge clk_sys_in) chk("masked", {15'h0, int_n_out}, 16'h1);
            @(posedge clk_sys_in) irq_event_in <= 8'h00;
            @(negedge clk_sys_in) chk("raised", {15'h0, int_n_out}, 16'h0);
            chk("pending", {8'h00, irq_pending_out}, {8'h00, 8'h01 << k});
            cyc(3);
            chk("sticky", {15'h0, int_n_out}, 16'h0);
            host.rd(dhs_pkg::INT_STATUS_ADDR, 2, d);
            cyc(1);
            chk("cleared", {15'h0, int_n_out}, 16'h1);
        end
        $display("interrupt test done");
    endtask : t_irq
    task t_dma;
        for (k = 0; k < 4; k++) begin
            @(posedge clk_sys_in) fifo_count_in <= cnt[k];
            cyc(2);
            chk("dma", {15'h0, dma_request_out}, {15'h0, dx[k]});
        end
        $display("dma test done");
    endtask : t_dma
    task t_sync_in(input logic cmp);
        @(posedge clk_sys_in) op_compare_in <= cmp;
        sync_in <= 1'b1;
        cyc(2);
        chk("held", {15'h0, sample_hold_out}, 16'h1);
        cyc(1);
        chk("start", {14'h0, start_compare_out, start_convert_out},
            {14'h0, cmp, ~cmp});
        chk("mux", {9'h0, mux_pos_out, mux_neg_out, mux_diff_out},
            {9'h0, 3'h6, 3'h1, 1'b1});
        @(posedge clk_sys_in) op_done_in <= 1'b1;
        @(posedge clk_sys_in) op_done_in <= 1'b0;
        sync_in <= 1'b0;
        @(negedge clk_sys_in) chk("done", {15'h0, sample_hold_out}, 16'h0);
        $display("sync input test done");
    endtask : t_sync_in
    task t_halt;
        @(posedge clk_sys_in) sync_in <= 1'b1;
        host.rd(5'h03, 3, d);
        cyc(1);
        chk("halted", {14'h0, sample_hold_out, start_convert_out},
            16'h0002);
        chk("run off", {15'h0, run_seen}, 16'h0000);
        cyc(1);
        chk("resumed", {15'h0, start_convert_out}, 16'h0001);
        @(posedge clk_sys_in) op_done_in <= 1'b1;
        @(posedge clk_sys_in) op_done_in <= 1'b0;
        sync_in <= 1'b0;
        $display("halt test done");
    endtask : t_halt
    task t_sync_out;
        @(posedge clk_sys_in) io_select_in <= 1'b1;
        cyc(2);
        chk("drive", {15'h0, sync_oe_out}, 16'h1);
        @(posedge clk_sys_in) op_start_req_in <= 1'b1;
        @(posedge clk_sys_in) op_start_req_in <= 1'b0;
        @(negedge clk_sys_in) chk("busy", {15'h0, sync_out}, 16'h1);
        @(posedge clk_sys_in) op_done_in <= 1'b1;
        @(posedge clk_sys_in) op_done_in <= 1'b0;
        io_select_in <= 1'b0;
        @(negedge clk_sys_in) chk("ended", {15'h0, sync_out}, 16'h0);
        cyc(1);
        chk("input", {15'h0, sync_oe_out}, 16'h0);
        $display("sync output test done");
    endtask : t_sync_out

    initial begin
        repeat (20) @(posedge clk_sys_in);
        reset_in <= 1'b0;
        cyc(1);
        chk("dir reset", {15'h0, sync_oe_out}, 16'h0);
        t_bus;
        t_irq;
        t_dma;
        t_sync_in(1'b1);
        t_sync_in(1'b0);
        t_halt;
        t_sync_out;
        wrap_up;
    end
endmodule : test_dhs_host_port
